// File: rtl/dpwm_pkg.sv
// ============================================================
// Shared constants for the dual PWM block
package dpwm_pkg;

  // ============================================================
  // Register addresses (7-bit)
  localparam logic [6:0] ADDR_CH_A_DUTY   = 7'h18;
  localparam logic [6:0] ADDR_CH_B_DUTY   = 7'h19;
  localparam logic [6:0] ADDR_PERIOD_SEL  = 7'h1c;
  localparam logic [6:0] ADDR_HOST_SCR    = 7'h1e;
  localparam logic [6:0] ADDR_EVENT_STAT  = 7'h47;

  // ============================================================
  // Field positions and reset values
  localparam int         PSEL_A_BIT       = 0;
  localparam int         PSEL_B_BIT       = 2;
  localparam logic [7:0] DUTY_RST         = 8'h00;
  localparam logic [7:0] SCR_RST          = 8'h00;
  localparam logic [7:0] STAT_RST         = 8'h00;
  localparam logic [7:0] STAT_RC_MASK     = 8'h7f;
  localparam logic [7:0] STAT_WD_MASK     = 8'h03;

  // ============================================================
  // SPI frame layout
  localparam int         FRAME_BITS       = 16;
  localparam int         FRAME_ACC_BIT    = 7;
  localparam int         FRAME_DATA_LSB   = 8;
  localparam logic [4:0] FRAME_LAST       = 5'd16;

  // ============================================================
  // PWM timing
  localparam int         CLK_HZ           = 50_000_000;
  localparam int         PWM_STEPS        = 255;
  localparam int         FREQ_LOW_HZ      = 200;
  localparam int         FREQ_HIGH_HZ     = 400;
  localparam int         STEP_LOW_CYC     = CLK_HZ / (FREQ_LOW_HZ * PWM_STEPS);
  localparam int         STEP_HIGH_CYC    = CLK_HZ / (FREQ_HIGH_HZ * PWM_STEPS);
  localparam logic [9:0] STEP_LOW_LAST    = 10'(STEP_LOW_CYC - 1);
  localparam logic [9:0] STEP_HIGH_LAST   = 10'(STEP_HIGH_CYC - 1);
  localparam logic [7:0] PHASE_LAST       = 8'(PWM_STEPS - 1);

  // Channel period select encoding
  typedef enum logic [0:0] {
    DPWM_RATE_200 = 1'b0,
    DPWM_RATE_400 = 1'b1
  } dpwm_rate_t;

endpackage

// File: rtl/dpwm_top.sv
// Function
// - Channel A duty is an 8-bit field, bit 0 LSB; zero means output always off
// - Duty N gives on-time N/255 of the period; all ones means always on
// - Channel B has its own 8-bit duty field with identical encoding
// - Period select at 0x1c: bit 0 channel A, bit 2 channel B; 0=200Hz, 1=400Hz
// - Period select bits 7:3 and 1 read zero and ignore writes
// - Channel A duty at 0x18, cleared by power-on and soft reset, kept on restart
// - Channel B duty at 0x19, cleared by power-on and soft reset, kept on restart
// - Host scratch byte at 0x1e, read/write, zero after power-up
// - Host scratch byte keeps its value across soft reset
// - Host scratch byte accessible over SPI only in Normal mode
// - Internal logic never changes the scratch byte; fail-safe or restart keep it
// - SPI frame is 16 bits: 7-bit address, access bit, then data byte
// - Register data bits 0..7 sit at frame bits 8..15
// - Frame bit 7 low reads a status register without changing it
// - Frame bit 7 high clears the clearable bits of the addressed status register
// - Status bits are read-only (reserved included) or read-and-clear
// - Only watchdog failure bits clear themselves; others need an SPI clear
`timescale 1ns/1ns
module dpwm_top
  import dpwm_pkg::*;
(
  // System clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Device mode and reset requests
  input  wire logic       normal_mode,
  input  wire logic       soft_rst,
  // Status event sources
  input  wire logic [6:0] status_set,
  input  wire logic       watchdog_failure_bits_release,
  // SPI link
  input  wire logic       spi_sck,
  input  wire logic       spi_csn,
  input  wire logic       spi_mosi,
  output logic            spi_miso,
  output logic            spi_miso_oe,
  // PWM outputs to the switch selector
  output logic            pwm_a_out,
  output logic            pwm_b_out
);

  // ============================================================
  // Link domain: shift in frames on sck rising edges
  logic        link_rst;
  logic [4:0]  bit_cnt_q;
  logic [15:0] shift_q;
  logic [15:0] frame_q;
  logic        frame_tgl_q;
  logic        miso_q;
  logic [7:0]  rdata_q;

  // Frame logic is cleared while chip select is high
  assign link_rst = sys_rst | spi_csn;

  // Bit counter and shift register, LSB first
  always_ff @(posedge spi_sck or posedge link_rst) begin
    if (link_rst) begin
      bit_cnt_q <= 5'd0;
      shift_q   <= 16'h0000;
    end else if (bit_cnt_q != FRAME_LAST) begin
      bit_cnt_q <= bit_cnt_q + 5'd1;
      shift_q   <= {spi_mosi, shift_q[15:1]};
    end
  end

  // Frame hand-off word and toggle; only a full 16-bit frame counts
  always_ff @(posedge spi_sck or posedge sys_rst) begin
    if (sys_rst) begin
      frame_q     <= 16'h0000;
      frame_tgl_q <= 1'b0;
    end else if (!spi_csn && bit_cnt_q == FRAME_LAST - 5'd1) begin
      frame_q     <= {spi_mosi, shift_q[15:1]};
      frame_tgl_q <= ~frame_tgl_q;
    end
  end

  // MISO changes on falling edges; data byte returns the previous frame's read
  always_ff @(negedge spi_sck or posedge link_rst) begin
    if (link_rst) begin
      miso_q <= 1'b0;
    end else if (bit_cnt_q >= 5'd8 && bit_cnt_q < FRAME_LAST) begin
      miso_q <= rdata_q[3'(bit_cnt_q - 5'd8)];
    end else begin
      miso_q <= 1'b0;
    end
  end

  assign spi_miso    = miso_q;
  assign spi_miso_oe = ~spi_csn;

  // ============================================================
  // Crossing of the frame event into the system domain
  logic       tgl_meta_q;
  logic       tgl_sync_q;
  logic       tgl_seen_q;
  logic       frame_acc;
  logic [6:0] f_addr;
  logic       f_acc;
  logic [7:0] f_data;

  // Two-stage synchroniser on the toggle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tgl_meta_q <= 1'b0;
      tgl_sync_q <= 1'b0;
      tgl_seen_q <= 1'b0;
    end else begin
      tgl_meta_q <= frame_tgl_q;
      tgl_sync_q <= tgl_meta_q;
      tgl_seen_q <= tgl_sync_q;
    end
  end

  // Frame word is stable long before the toggle arrives here
  assign frame_acc = tgl_sync_q ^ tgl_seen_q;
  assign f_addr    = frame_q[6:0];
  assign f_acc     = frame_q[FRAME_ACC_BIT];
  assign f_data    = frame_q[FRAME_BITS-1:FRAME_DATA_LSB];

  // Write strobe decode for a given address
  function automatic logic wr_hit(input logic [6:0] a);
    return frame_acc && f_acc && (f_addr == a);
  endfunction

  // ============================================================
  // Configuration and status registers
  logic [7:0] duty_a_q;
  logic [7:0] duty_b_q;
  logic       psel_a_q;
  logic       psel_b_q;
  logic [7:0] scratch_q;
  logic [7:0] stat_q;
  logic [7:0] stat_d;
  logic       stat_clr;

  // Duty and period select, cleared by soft reset, kept on restart
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      duty_a_q <= DUTY_RST;
      duty_b_q <= DUTY_RST;
      psel_a_q <= DPWM_RATE_200;
      psel_b_q <= DPWM_RATE_200;
    end else if (soft_rst) begin
      duty_a_q <= DUTY_RST;
      duty_b_q <= DUTY_RST;
      psel_a_q <= DPWM_RATE_200;
      psel_b_q <= DPWM_RATE_200;
    end else begin
      if (wr_hit(ADDR_CH_A_DUTY)) duty_a_q <= f_data;
      if (wr_hit(ADDR_CH_B_DUTY)) duty_b_q <= f_data;
      if (wr_hit(ADDR_PERIOD_SEL)) begin
        psel_a_q <= f_data[PSEL_A_BIT];
        psel_b_q <= f_data[PSEL_B_BIT];
      end
    end
  end

  // Host scratch byte: only SPI in Normal mode changes it
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      scratch_q <= SCR_RST;
    end else if (wr_hit(ADDR_HOST_SCR) && normal_mode) begin
      scratch_q <= f_data;
    end
  end

  // Event status: sets win over clears, watchdog bits self-clear
  assign stat_clr = frame_acc && f_acc && (f_addr == ADDR_EVENT_STAT);
  always_comb begin
    stat_d = stat_q;
    if (stat_clr) begin
      stat_d = stat_d & ~STAT_RC_MASK;
    end
    if (watchdog_failure_bits_release) begin
      stat_d = stat_d & ~STAT_WD_MASK;
    end
    stat_d = (stat_d | {1'b0, status_set}) & STAT_RC_MASK;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      stat_q <= STAT_RST;
    end else if (soft_rst) begin
      stat_q <= STAT_RST;
    end else begin
      stat_q <= stat_d;
    end
  end

  // Read data for the next frame, captured before any clear
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_q <= 8'h00;
    end else if (frame_acc) begin
      unique case (f_addr)
        ADDR_CH_A_DUTY:  rdata_q <= duty_a_q;
        ADDR_CH_B_DUTY:  rdata_q <= duty_b_q;
        ADDR_PERIOD_SEL: rdata_q <= {5'h00, psel_b_q, 1'b0, psel_a_q};
        ADDR_HOST_SCR:   rdata_q <= normal_mode ? scratch_q : 8'h00;
        ADDR_EVENT_STAT: rdata_q <= stat_q;
        default:         rdata_q <= 8'h00;
      endcase
    end
  end

  // ============================================================
  // PWM timebases, one per channel
  logic [9:0] div_a_q;
  logic [9:0] div_b_q;
  logic [7:0] ph_a_q;
  logic [7:0] ph_b_q;
  logic [7:0] act_a_q;
  logic [7:0] act_b_q;
  logic       step_a;
  logic       step_b;
  logic       wrap_a;
  logic       wrap_b;

  // Divider terminal count for the selected period
  function automatic logic [9:0] step_last(input logic sel);
    return (sel == DPWM_RATE_400) ? STEP_HIGH_LAST : STEP_LOW_LAST;
  endfunction

  assign step_a = (div_a_q >= step_last(psel_a_q));
  assign step_b = (div_b_q >= step_last(psel_b_q));
  assign wrap_a = step_a && (ph_a_q == PHASE_LAST);
  assign wrap_b = step_b && (ph_b_q == PHASE_LAST);

  // Step dividers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      div_a_q <= 10'd0;
      div_b_q <= 10'd0;
    end else begin
      div_a_q <= step_a ? 10'd0 : div_a_q + 10'd1;
      div_b_q <= step_b ? 10'd0 : div_b_q + 10'd1;
    end
  end

  // 255-step phase counters, 0..254
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ph_a_q <= 8'h00;
      ph_b_q <= 8'h00;
    end else begin
      if (step_a) ph_a_q <= wrap_a ? 8'h00 : ph_a_q + 8'h01;
      if (step_b) ph_b_q <= wrap_b ? 8'h00 : ph_b_q + 8'h01;
    end
  end

  // Active duty reloads at the period boundary
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      act_a_q <= DUTY_RST;
      act_b_q <= DUTY_RST;
    end else begin
      if (wrap_a) act_a_q <= duty_a_q;
      if (wrap_b) act_b_q <= duty_b_q;
    end
  end

  // Compare outputs: 0 never on, 255 always on
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pwm_a_out <= 1'b0;
      pwm_b_out <= 1'b0;
    end else begin
      pwm_a_out <= (ph_a_q < act_a_q);
      pwm_b_out <= (ph_b_q < act_b_q);
    end
  end

  // ============================================================
  // Checks
  int unsigned gap_a_q;

  // Cycles since the last channel A step
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      gap_a_q <= 0;
    end else begin
      gap_a_q <= step_a ? 0 : gap_a_q + 1;
    end
  end

  sequence s_frame_hits(logic [6:0] a);
    frame_acc && f_acc && f_addr == a && !soft_rst;
  endsequence

  a_duty_off_zero: assert property (@(posedge clk) disable iff (sys_rst)
    act_a_q == 8'h00 |=> !pwm_a_out)
    else $error("channel A on with zero duty");

  a_duty_full_on: assert property (@(posedge clk) disable iff (sys_rst)
    act_a_q == 8'hff && $stable(act_a_q) |=> pwm_a_out)
    else $error("channel A off with full duty");

  a_duty_b_write: assert property (@(posedge clk) disable iff (sys_rst)
    s_frame_hits(ADDR_CH_B_DUTY) |=> duty_b_q == $past(f_data))
    else $error("channel B duty write lost");

  a_step_rate_sel: assert property (@(posedge clk) disable iff (sys_rst)
    step_a && $past(step_a) == 1'b0 && $stable(psel_a_q)
      |-> gap_a_q == 32'((psel_a_q == DPWM_RATE_400) ? STEP_HIGH_CYC - 1 : STEP_LOW_CYC - 1))
    else $error("channel A step spacing wrong");

  a_psel_rsvd_zero: assert property (@(posedge clk) disable iff (sys_rst)
    frame_acc && f_addr == ADDR_PERIOD_SEL |=> rdata_q[7:3] == 5'h00 && !rdata_q[1])
    else $error("period select reserved bits nonzero");

  a_soft_rst_clr: assert property (@(posedge clk) disable iff (sys_rst)
    soft_rst |=> duty_a_q == 8'h00 && duty_b_q == 8'h00)
    else $error("duty not cleared by soft reset");

  a_scratch_keep: assert property (@(posedge clk) disable iff (sys_rst)
    soft_rst && !wr_hit(ADDR_HOST_SCR) |=> $stable(scratch_q))
    else $error("scratch changed on soft reset");

  a_scratch_mode: assert property (@(posedge clk) disable iff (sys_rst)
    wr_hit(ADDR_HOST_SCR) && normal_mode |=> scratch_q == $past(f_data))
    else $error("scratch write in normal mode lost");

  a_scratch_locked: assert property (@(posedge clk) disable iff (sys_rst)
    !(wr_hit(ADDR_HOST_SCR) && normal_mode) |=> $stable(scratch_q))
    else $error("scratch changed without host write");

  a_stat_read_keep: assert property (@(posedge clk) disable iff (sys_rst)
    frame_acc && !f_acc && status_set == 7'h00 && !watchdog_failure_bits_release && !soft_rst
      |=> $stable(stat_q))
    else $error("status read altered contents");

  a_stat_set_wins: assert property (@(posedge clk) disable iff (sys_rst)
    stat_clr && status_set[6] && !soft_rst |=> stat_q[6])
    else $error("status event lost during clear");

  a_stat_rsvd_zero: assert property (@(posedge clk) disable iff (sys_rst)
    !stat_q[7])
    else $error("status reserved bit set");

  a_stat_no_selfclr: assert property (@(posedge clk) disable iff (sys_rst)
    stat_q[4] && !stat_clr && !soft_rst |=> stat_q[4])
    else $error("status bit cleared by itself");

  a_duty_reload: assert property (@(posedge clk) disable iff (sys_rst)
    !wrap_a |=> $stable(act_a_q))
    else $error("duty changed inside a period");

  a_duty_a_write: assert property (@(posedge clk) disable iff (sys_rst)
    s_frame_hits(ADDR_CH_A_DUTY) |=> duty_a_q == $past(f_data))
    else $error("channel A duty write lost");

  a_psel_write: assert property (@(posedge clk) disable iff (sys_rst)
    s_frame_hits(ADDR_PERIOD_SEL) |=> {5'h00, psel_b_q, 1'b0, psel_a_q} == ($past(f_data) & 8'h05))
    else $error("period select write wrong");

  a_stat_clear: assert property (@(posedge clk) disable iff (sys_rst)
    stat_clr && status_set == 7'h00 && !soft_rst |=> stat_q == 8'h00)
    else $error("status clear incomplete");

  a_stat_wd_clear: assert property (@(posedge clk) disable iff (sys_rst)
    watchdog_failure_bits_release && status_set == 7'h00 && !soft_rst |=> stat_q[1:0] == 2'b00)
    else $error("watchdog bits not released");

  a_pwm_b_off: assert property (@(posedge clk) disable iff (sys_rst)
    act_b_q == 8'h00 |=> !pwm_b_out)
    else $error("channel B on with zero duty");

  a_scratch_blocked: assert property (@(posedge clk) disable iff (sys_rst)
    wr_hit(ADDR_HOST_SCR) && !normal_mode |=> $stable(scratch_q))
    else $error("scratch written outside normal mode");

  a_scratch_hidden: assert property (@(posedge clk) disable iff (sys_rst)
    frame_acc && f_addr == ADDR_HOST_SCR && !normal_mode |=> rdata_q == 8'h00)
    else $error("scratch readable outside normal mode");

  a_stat_read_data: assert property (@(posedge clk) disable iff (sys_rst)
    frame_acc && f_addr == ADDR_EVENT_STAT |=> rdata_q == $past(stat_q))
    else $error("status read data wrong");

endmodule // dpwm_top

// File: verification/dpwm_spi_master.sv
`timescale 1ns/1ns
// ============================================================
// SPI master model standing in for the microcontroller
module dpwm_spi_master (
  // SPI link
  output logic      spi_sck,
  output logic      spi_csn,
  output logic      spi_mosi,
  input  wire logic spi_miso
);
  // Idle link: clock still and low, chip select high
  initial begin
    spi_sck  = 1'b0;
    spi_csn  = 1'b1;
    spi_mosi = 1'b0;
  end

  // One 16-bit frame, LSB first; returns frame bits 8..15 seen on miso
  task automatic xfer(input logic [6:0] addr, input logic acc, input logic [7:0] wdat,
                      output logic [7:0] rdat);
    logic [15:0] frame;
    frame = {wdat, acc, addr};
    #7 spi_csn = 1'b0;
    for (int k = 0; k < 16; k++) begin
      spi_mosi = frame[k];
      #62 spi_sck = 1'b1;
      if (k >= 8) begin
        rdat[k-8] = spi_miso;
      end
      #63 spi_sck = 1'b0;
    end
    #63 spi_csn = 1'b1;
    spi_mosi = ~spi_mosi;  // Released line carries no stale value
    #300;                  // Gap between frames
  endtask
endmodule // dpwm_spi_master

// File: verification/dpwm_top_tb_top.sv
`timescale 1ns/1ns
// ============================================================
// Self-checking bench for the dual PWM block
module dpwm_top_tb_top
  import dpwm_pkg::*;
;
  logic       clk;
  logic       sys_rst;
  logic       normal_mode;
  logic       soft_rst;
  logic [6:0] status_set;
  logic       watchdog_failure_bits_release;
  logic       spi_sck;
  logic       spi_csn;
  logic       spi_mosi;
  logic       spi_miso;
  logic       spi_miso_oe;
  logic       pwm_a_out;
  logic       pwm_b_out;
  logic [7:0] rv;
  int         n_fail = 0;
  int         checks_done = 0;

  // ============================================================
  // Design and partner
  dpwm_top dpwm_top_i (.clk(clk), .sys_rst(sys_rst), .normal_mode(normal_mode),
    .soft_rst(soft_rst), .status_set(status_set), .watchdog_failure_bits_release(watchdog_failure_bits_release),
    .spi_sck(spi_sck), .spi_csn(spi_csn), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
    .spi_miso_oe(spi_miso_oe), .pwm_a_out(pwm_a_out), .pwm_b_out(pwm_b_out));
  dpwm_spi_master dpwm_spi_master_i (.spi_sck(spi_sck), .spi_csn(spi_csn),
    .spi_mosi(spi_mosi), .spi_miso(spi_miso));

  // 50 MHz system clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ============================================================
  // Compare, access and closing tasks
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chkn(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    dpwm_spi_master_i.xfer(a, 1'b1, d, rv);
  endtask

  // Read data comes back one frame late, so the address is sent twice
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    dpwm_spi_master_i.xfer(a, 1'b0, 8'h00, d);
    dpwm_spi_master_i.xfer(a, 1'b0, 8'h00, d);
  endtask

  task automatic conclude;
    $display("Checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ============================================================
  // Scenarios
  task automatic t_reset;
    chk8("miso idle", 8'h00, {6'h00, spi_miso_oe, spi_miso});
    // Output enable must follow chip select while a frame runs
    fork
      rd(ADDR_CH_A_DUTY, rv);
      begin
        #200;
        chk8("miso oe active", 8'h01, {7'h00, spi_miso_oe});
      end
    join
    chk8("duty a reset", DUTY_RST, rv);
    rd(ADDR_CH_B_DUTY, rv);
    chk8("duty b reset", DUTY_RST, rv);
    rd(ADDR_PERIOD_SEL, rv);
    chk8("period sel reset", 8'h00, rv);
    rd(ADDR_HOST_SCR, rv);
    chk8("scratch reset", SCR_RST, rv);
    $display("test reset done");
  endtask

  task automatic t_regs;
    wr(ADDR_CH_A_DUTY, 8'ha5);
    wr(ADDR_CH_B_DUTY, 8'h5a);
    wr(ADDR_PERIOD_SEL, 8'hff);
    wr(ADDR_HOST_SCR, 8'h3c);
    wr(7'h20, 8'hff);
    rd(ADDR_CH_A_DUTY, rv);
    chk8("duty a", 8'ha5, rv);
    rd(ADDR_CH_B_DUTY, rv);
    chk8("duty b", 8'h5a, rv);
    rd(ADDR_PERIOD_SEL, rv);
    chk8("period sel", 8'h05, rv);
    rd(ADDR_HOST_SCR, rv);
    chk8("scratch", 8'h3c, rv);
    rd(7'h20, rv);
    chk8("unmapped", 8'h00, rv);
    $display("test regs done");
  endtask

  task automatic t_mode;
    @(posedge clk) normal_mode <= 1'b0;
    wr(ADDR_HOST_SCR, 8'hc3);
    rd(ADDR_HOST_SCR, rv);
    chk8("scratch blocked", 8'h00, rv);
    @(posedge clk) normal_mode <= 1'b1;
    rd(ADDR_HOST_SCR, rv);
    chk8("scratch kept", 8'h3c, rv);
    $display("test mode done");
  endtask

  task automatic t_soft;
    @(posedge clk) soft_rst <= 1'b1;
    @(posedge clk) soft_rst <= 1'b0;
    rd(ADDR_CH_A_DUTY, rv);
    chk8("duty a soft", DUTY_RST, rv);
    rd(ADDR_CH_B_DUTY, rv);
    chk8("duty b soft", DUTY_RST, rv);
    rd(ADDR_PERIOD_SEL, rv);
    chk8("period sel soft", 8'h00, rv);
    rd(ADDR_HOST_SCR, rv);
    chk8("scratch soft", 8'h3c, rv);
    $display("test soft done");
  endtask

  task automatic t_status;
    @(posedge clk) status_set <= 7'h7f;
    @(posedge clk) status_set <= 7'h00;
    rd(ADDR_EVENT_STAT, rv);
    chk8("status set", 8'h7f, rv);
    @(posedge clk) watchdog_failure_bits_release <= 1'b1;
    @(posedge clk) watchdog_failure_bits_release <= 1'b0;
    rd(ADDR_EVENT_STAT, rv);
    chk8("status wd release", 8'h7c, rv);
    // Event held high across a clear must survive it
    @(posedge clk) status_set <= 7'h40;
    wr(ADDR_EVENT_STAT, 8'h00);
    @(posedge clk) status_set <= 7'h00;
    rd(ADDR_EVENT_STAT, rv);
    chk8("status set wins", 8'h40, rv);
    wr(ADDR_EVENT_STAT, 8'h00);
    rd(ADDR_EVENT_STAT, rv);
    chk8("status cleared", 8'h00, rv);
    $display("test status done");
  endtask

  // Both channels at 400 Hz: one step is 490 clocks
  task automatic t_pwm;
    int n;
    wr(ADDR_PERIOD_SEL, 8'h05);
    wr(ADDR_CH_A_DUTY, 8'hff);
    wr(ADDR_CH_B_DUTY, 8'h03);
    chk8("pwm a before wrap", 8'h00, {7'h00, pwm_a_out});
    for (n = 0; n < 140000 && pwm_b_out !== 1'b1; n++) @(negedge clk);
    chk8("pwm b start", 8'h01, {7'h00, pwm_b_out});
    chk8("pwm a full on", 8'h01, {7'h00, pwm_a_out});
    n = 0;
    while (pwm_b_out === 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    chkn("pwm b on time", 32'(3 * STEP_HIGH_CYC), n);
    chk8("pwm a steady", 8'h01, {7'h00, pwm_a_out});
    wr(ADDR_CH_A_DUTY, 8'h00);
    chk8("pwm a waits period", 8'h01, {7'h00, pwm_a_out});
    $display("test pwm done");
  endtask

  // ============================================================
  // Main sequence
  initial begin
    sys_rst = 1'b1;
    normal_mode = 1'b1;
    soft_rst = 1'b0;
    status_set = 7'h00;
    watchdog_failure_bits_release = 1'b0;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk);
    t_reset;
    t_regs;
    t_mode;
    t_soft;
    t_status;
    t_pwm;
    conclude;
  end

  // Watchdog: all scenarios end well within this span
  initial begin
    repeat (200000) @(posedge clk);
    n_fail++;
    conclude;
  end
endmodule // dpwm_top_tb_top
